// ---- src/cpusl_pkg.sv ----
// cpu module support logic package: state codes, cycle codes, timing counts
// assumes a 10 MHz system clock sampling the processor's pins synchronously
package cpusl_pkg;
  // state code lines read as {bit2,bit1,bit0}
  localparam logic [2:0] STATE_FIRST      = 3'h2;
  localparam logic [2:0] STATE_INT_FIRST  = 3'h6;
  localparam logic [2:0] STATE_SECOND     = 3'h4;
  localparam logic [2:0] STATE_WAIT       = 3'h0;
  localparam logic [2:0] STATE_THIRD      = 3'h1;
  localparam logic [2:0] STATE_STOPPED    = 3'h3;
  localparam logic [2:0] STATE_FOURTH     = 3'h7;
  localparam logic [2:0] STATE_FIFTH      = 3'h5;
  // cycle bits as {d7,d6}
  localparam logic [1:0] CYC_FETCH        = 2'h0;
  localparam logic [1:0] CYC_READ         = 2'h2;
  localparam logic [1:0] CYC_IO           = 2'h1;
  localparam logic [1:0] CYC_WRITE        = 2'h3;
  localparam int         CYC_D6_BIT       = 6;
  localparam int         CYC_D7_BIT       = 7;
  // processor clock and system clock
  localparam int         CLK_HZ           = 10_000_000;
  localparam int         PHASE_HZ         = 800_000;
  localparam int         SYNC_HZ          = 400_000;
  localparam int         PHASE_PERIOD_CYC = CLK_HZ / PHASE_HZ;
  localparam int         PHASE_HALF_CYC   = PHASE_PERIOD_CYC / 2;
  localparam logic [3:0] PHASE_LAST       = 4'(PHASE_PERIOD_CYC - 1);
  localparam logic [3:0] PHI1_END         = 4'(PHASE_HALF_CYC / 2);
  localparam logic [3:0] PHI2_START       = 4'(PHASE_HALF_CYC);
  localparam logic [3:0] PHI2_END         = 4'(PHASE_HALF_CYC + PHASE_HALF_CYC / 2);
  localparam logic [7:0] BYTE_RESET       = 8'h00;
  // input multiplexer selection
  typedef enum logic [2:0] {
    CPUSL_SRC_MEM  = 3'h1,
    CPUSL_SRC_PERI = 3'h2,
    CPUSL_SRC_INTR = 3'h4
  } cpusl_src_type;
endpackage

// ---- src/cpusl_latch8.sv ----
// cpu module support logic: eight-bit strobed latch with registered output
// assumes strobe and data are synchronous to clk
`timescale 1ns/1ps
module cpusl_latch8 (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       strobe,
  input  wire logic [7:0] d,
  output logic      [7:0] q
);
  import cpusl_pkg::*;
  logic [7:0] q_reg;
  logic [7:0] q_next;
  always_comb begin
    q_next = strobe ? d : q_reg;
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      q_reg <= BYTE_RESET;
    end else begin
      q_reg <= q_next;
    end
  end
  assign q = q_reg;
endmodule // cpusl_latch8

// ---- src/cpusl_top.sv ----
// cpu module support logic: timing, cycle decode, bus steering, latches,
// wait, interrupt and hold handling around an eight-bit processor chip.
// assumes processor pins are sampled synchronously at clk; the phases are
// generated here by dividing clk, the sync arrives from the processor.
// Operation
// - latch cycle bits in second state, decode exclusive fetch/read/write/io outputs
// - derive combined phase from phases, buffered sync from sync, third-state aux from third state and buffered sync
// - multiplexer routes one of memory, peripheral or interrupt bytes to cpu
// - bus control picks source from third aux, io, write, interrupt, hold
// - input gate drives cpu bus only in third aux of non-write cycles
// - output data bus driven always except during hold
// - two address latches capture bus in first and second states
// - read/write line shows write only in third state of write cycle
// - stall request idles processor and raises wait acknowledge until withdrawn
// - processor idle intervals last an even number of clock periods
// - interrupt requests synchronised via buffered sync; latch seen exported
// - interrupt makes next fetch start in interrupt first state
// - interrupt first state steers multiplexer to interrupt instruction port
// - bus yield granted only when request meets wait or stopped state
// - while granted, address, data, rw and io strobes float; states off
// - hold persists while stall request stays asserted
// - status latch captures cpu output byte in fourth state
// - cycle code from bits 6,7: fetch 00, read 01, io 10, write 11
// - state lines decode to the eight documented states
// - two non-overlapping 833 kHz phases (12 clk periods), sync at 417 kHz
`timescale 1ns/1ps
module cpusl_top (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [2:0] state_code_lines,
  input  wire logic       cpu_sync,
  input  wire logic [7:0] cpu_data_out,
  input  wire logic [7:0] mem_read_data,
  input  wire logic [7:0] peri_in_data,
  input  wire logic [7:0] intr_instr_data,
  input  wire logic       slow_memory_stall_req,
  input  wire logic       service_req,
  input  wire logic       stop_service_req,
  input  wire logic       bus_yield_req,
  output logic            phase1,
  output logic            phase2,
  output logic            combined_phase_n,
  output logic            sync_buffered,
  output logic            third_state_aux,
  output logic [7:0]      cpu_data_in,
  output logic            cpu_data_in_oe_n,
  output logic            cpu_ready,
  output logic            cpu_interrupt,
  output logic            fetch_cycle,
  output logic            mem_read_cycle,
  output logic            mem_write_cycle,
  output logic            io_cycle,
  output logic [7:0]      state_outputs,
  output logic [7:0]      addr_low,
  output logic [7:0]      addr_high,
  output logic            addr_oe_n,
  output logic [7:0]      data_out,
  output logic            data_out_oe_n,
  output logic            mem_write_n,
  output logic            mem_rw_oe_n,
  output logic            io_write_strobe,
  output logic            io_read_strobe,
  output logic            io_strobe_oe_n,
  output logic            wait_ack,
  output logic            service_req_seen,
  output logic            bus_yield_grant,
  output logic [7:0]      status_flags
);
  import cpusl_pkg::*;

  // phase generator; a state spans two phase periods
  logic [3:0] div_reg, div_next;
  logic       ph1_reg, ph1_next, ph2_reg, ph2_next;
  always_comb begin
    div_next = (div_reg == PHASE_LAST) ? 4'h0 : div_reg + 4'h1;
    ph1_next = (div_next < PHI1_END);
    ph2_next = (div_next >= PHI2_START) && (div_next < PHI2_END);
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      div_reg <= 4'h0;
      ph1_reg <= 1'b0;
      ph2_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      ph1_reg <= ph1_next;
      ph2_reg <= ph2_next;
    end
  end
  wire logic ph2_rise = ph2_next && !ph2_reg;

  // state decode, one-hot
  logic [7:0] st;
  localparam int ST_T1 = 0, ST_T1I = 1, ST_T2 = 2, ST_WT = 3;
  localparam int ST_T3 = 4, ST_STP = 5, ST_T4 = 6, ST_T5 = 7;
  always_comb begin
    st = 8'h00;
    unique case (state_code_lines)
      STATE_FIRST:     st[ST_T1]  = 1'b1;
      STATE_INT_FIRST: st[ST_T1I] = 1'b1;
      STATE_SECOND:    st[ST_T2]  = 1'b1;
      STATE_WAIT:      st[ST_WT]  = 1'b1;
      STATE_THIRD:     st[ST_T3]  = 1'b1;
      STATE_STOPPED:   st[ST_STP] = 1'b1;
      STATE_FOURTH:    st[ST_T4]  = 1'b1;
      STATE_FIFTH:     st[ST_T5]  = 1'b1;
    endcase
  end

  // cycle decoder, auxiliary timing, interrupt, wait and hold state
  logic [1:0] cyc_reg, cyc_next;
  logic       sync_reg, sync_next, t3a_reg, t3a_next, c12_reg, c12_next;
  logic       irq_reg, irq_next, int_reg, int_next;
  logic       wait_reg, wait_next, hold_reg, hold_next;
  logic       odd_reg, odd_next;
  logic       jam_reg, jam_next;
  always_comb begin
    cyc_next = cyc_reg;
    if (st[ST_T2] && ph2_rise) begin
      cyc_next = {cpu_data_out[CYC_D7_BIT], cpu_data_out[CYC_D6_BIT]};
    end
    sync_next = cpu_sync;
    c12_next  = !(ph1_next || ph2_next);
    t3a_next  = st[ST_T3] && sync_reg;
    // request latched on buffered sync edges; either request sets it, and a set wins over the interrupt first clear
    irq_next = irq_reg;
    if (st[ST_T1I]) begin
      irq_next = 1'b0;
    end
    if (sync_next && !sync_reg) begin
      if (stop_service_req || service_req) begin
        irq_next = 1'b1;
      end
    end
    int_next = irq_reg;
    // jam must outlive the request latch: the byte is taken in third state
    jam_next = jam_reg;
    if (st[ST_T1I]) begin
      jam_next = 1'b1;
    end else if (st[ST_T1]) begin
      jam_next = 1'b0;
    end
    // idle toggles only on every second clk, keeping idle even
    odd_next  = !odd_reg;
    wait_next = wait_reg;
    if (!odd_reg) begin
      wait_next = slow_memory_stall_req;
    end
    hold_next = hold_reg;
    if (!hold_reg && bus_yield_req && (st[ST_WT] || st[ST_STP])) begin
      hold_next = 1'b1;
    end else if (hold_reg && !slow_memory_stall_req && (!st[ST_STP] || !bus_yield_req)) begin
      hold_next = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      cyc_reg  <= CYC_FETCH;
      sync_reg <= 1'b0;
      c12_reg  <= 1'b1;
      t3a_reg  <= 1'b0;
      irq_reg  <= 1'b0;
      int_reg  <= 1'b0;
      wait_reg <= 1'b0;
      hold_reg <= 1'b0;
      odd_reg  <= 1'b0;
      jam_reg  <= 1'b0;
    end else begin
      cyc_reg  <= cyc_next;
      sync_reg <= sync_next;
      c12_reg  <= c12_next;
      t3a_reg  <= t3a_next;
      irq_reg  <= irq_next;
      int_reg  <= int_next;
      wait_reg <= wait_next;
      hold_reg <= hold_next;
      odd_reg  <= odd_next;
      jam_reg  <= jam_next;
    end
  end

  // bus control and input multiplexer
  cpusl_src_type src;
  logic [7:0]    mux_data;
  logic          gate_on;
  always_comb begin
    if (st[ST_T1I] || (cyc_reg == CYC_FETCH && jam_reg)) begin
      src = CPUSL_SRC_INTR;
    end else if (cyc_reg == CYC_IO) begin
      src = CPUSL_SRC_PERI;
    end else begin
      src = CPUSL_SRC_MEM;
    end
    unique case (src)
      CPUSL_SRC_MEM:  mux_data = mem_read_data;
      CPUSL_SRC_PERI: mux_data = peri_in_data;
      CPUSL_SRC_INTR: mux_data = intr_instr_data;
      default:        mux_data = mem_read_data;
    endcase
    gate_on = t3a_next && (cyc_reg != CYC_WRITE) && !hold_reg;
  end

  // registered outputs
  logic [7:0] din_reg, sto_reg;
  logic       din_oe_n_reg, mwn_reg, iow_reg, ior_reg, rdy_reg;
  logic [3:0] cyo_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      din_reg      <= BYTE_RESET;
      din_oe_n_reg <= 1'b1;
      sto_reg      <= BYTE_RESET;
      cyo_reg      <= 4'h0;
      mwn_reg      <= 1'b1;
      rdy_reg      <= 1'b1;
      iow_reg      <= 1'b0;
      ior_reg      <= 1'b0;
    end else begin
      din_reg      <= mux_data;
      din_oe_n_reg <= !gate_on;
      sto_reg      <= hold_next ? 8'h00 : st;
      cyo_reg      <= {cyc_next == CYC_IO, cyc_next == CYC_WRITE,
                       cyc_next == CYC_READ, cyc_next == CYC_FETCH};
      mwn_reg      <= !(st[ST_T3] && cyc_reg == CYC_WRITE);
      rdy_reg      <= !wait_next;
      iow_reg      <= t3a_next && cyc_reg == CYC_IO && cpu_data_out[CYC_D6_BIT];
      ior_reg      <= t3a_next && cyc_reg == CYC_IO && !cpu_data_out[CYC_D6_BIT];
    end
  end

  // address and status latches
  cpusl_latch8 u_addr_lo (
    .clk    (clk),
    .reset  (reset),
    .strobe (st[ST_T1] || st[ST_T1I]),
    .d      (cpu_data_out),
    .q      (addr_low)
  );
  cpusl_latch8 u_addr_hi (
    .clk    (clk),
    .reset  (reset),
    .strobe (st[ST_T2]),
    .d      (cpu_data_out),
    .q      (addr_high)
  );
  cpusl_latch8 u_status (
    .clk    (clk),
    .reset  (reset),
    .strobe (st[ST_T4] && ph2_rise),
    .d      (cpu_data_out),
    .q      (status_flags)
  );

  // data out register mirrors the processor bus every clk, in hold time too
  logic [7:0] dout_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      dout_reg <= BYTE_RESET;
    end else begin
      dout_reg <= cpu_data_out;
    end
  end

  assign phase1           = ph1_reg;
  assign phase2           = ph2_reg;
  assign combined_phase_n = c12_reg;
  assign sync_buffered    = sync_reg;
  assign third_state_aux  = t3a_reg;
  assign cpu_data_in      = din_reg;
  assign cpu_data_in_oe_n = din_oe_n_reg;
  assign cpu_ready        = rdy_reg;
  assign cpu_interrupt    = int_reg;
  assign fetch_cycle      = cyo_reg[0];
  assign mem_read_cycle   = cyo_reg[1];
  assign mem_write_cycle  = cyo_reg[2];
  assign io_cycle         = cyo_reg[3];
  assign state_outputs    = sto_reg;
  assign addr_oe_n        = hold_reg;
  assign data_out         = dout_reg;
  assign data_out_oe_n    = hold_reg;
  assign mem_write_n      = mwn_reg;
  assign mem_rw_oe_n      = hold_reg;
  assign io_write_strobe  = iow_reg;
  assign io_read_strobe   = ior_reg;
  assign io_strobe_oe_n   = hold_reg;
  assign wait_ack         = wait_reg;
  assign service_req_seen = irq_reg;
  assign bus_yield_grant  = hold_reg;

  a_wait_even: assert property (@(posedge clk) disable iff (reset)
    $changed(wait_reg) |-> odd_reg)
    else $error("wait changed off an even boundary");
  a_wait_follows: assert property (@(posedge clk) disable iff (reset)
    slow_memory_stall_req ##1 slow_memory_stall_req |=> wait_ack)
    else $error("stall request not acknowledged");
  a_grant_cause: assert property (@(posedge clk) disable iff (reset)
    $rose(bus_yield_grant) |-> $past(bus_yield_req) &&
      ($past(state_code_lines) == STATE_WAIT || $past(state_code_lines) == STATE_STOPPED))
    else $error("grant without request");
  a_hold_float: assert property (@(posedge clk) disable iff (reset)
    bus_yield_grant |-> data_out_oe_n && addr_oe_n && mem_rw_oe_n && io_strobe_oe_n &&
      state_outputs == 8'h00)
    else $error("bus driven during hold");
  a_hold_keep: assert property (@(posedge clk) disable iff (reset)
    bus_yield_grant && slow_memory_stall_req |=> bus_yield_grant)
    else $error("hold dropped while stall held");
  a_rw_write: assert property (@(posedge clk) disable iff (reset)
    !mem_write_n |-> $past(state_code_lines) == STATE_THIRD)
    else $error("write outside third state");
  a_cycle_onehot: assert property (@(posedge clk) disable iff (reset)
    $onehot({fetch_cycle, mem_read_cycle, mem_write_cycle, io_cycle}) || $past(reset))
    else $error("cycle outputs not exclusive");
  a_irq_clear: assert property (@(posedge clk) disable iff (reset)
    state_code_lines == STATE_INT_FIRST && !$rose(sync_buffered) && !cpu_sync
      |=> !service_req_seen)
    else $error("interrupt latch not cleared");
  a_gate_write: assert property (@(posedge clk) disable iff (reset)
    !cpu_data_in_oe_n |-> !mem_write_cycle)
    else $error("input gate open in write cycle");
  a_jam_select: assert property (@(posedge clk) disable iff (reset)
    state_code_lines == STATE_INT_FIRST |=> cpu_data_in == $past(intr_instr_data))
    else $error("interrupt port not selected");
endmodule // cpusl_top

// ---- sim/cpusl_far_model.sv ----
// far-side model of cpusl_top: memory, input port and dma peripheral
// assumes stall_go and dma_go are one-clk pulses; stall_len sets the answer speed
`timescale 1ns/1ps
module cpusl_far_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] addr_low,
  input  wire logic       addr_oe_n,
  input  wire logic [7:0] data_out,
  input  wire logic       mem_write_n,
  input  wire logic       mem_rw_oe_n,
  input  wire logic       bus_yield_grant,
  input  wire logic       stall_go,
  input  wire logic       dma_go,
  input  wire logic [7:0] stall_len,
  input  wire logic [7:0] peri_byte,
  output logic      [7:0] mem_read_data,
  output logic      [7:0] peri_in_data,
  output logic            slow_memory_stall_req,
  output logic            bus_yield_req
);
  logic [7:0] mem [256];
  logic [7:0] cnt      = 8'h00;
  logic       dma_wait = 1'b0;
  logic       yreq     = 1'b0;
  initial foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5a;
  // floated address selects nothing: show the inverse, never a stale byte
  assign mem_read_data = addr_oe_n ? ~mem[addr_low] : mem[addr_low];
  assign peri_in_data  = peri_byte;
  assign bus_yield_req = yreq;
  // the stall alone keeps the bus once granted
  assign slow_memory_stall_req = dma_wait || cnt != 8'h00;
  always @(posedge clk) begin
    if (reset) begin
      cnt <= 8'h00;
      dma_wait <= 1'b0;
      yreq <= 1'b0;
    end else begin
      if (!mem_write_n && !mem_rw_oe_n) mem[addr_low] <= data_out;
      if (cnt != 8'h00) cnt <= cnt - 8'h01;
      if (stall_go) cnt <= stall_len;
      if (dma_go) begin
        dma_wait <= 1'b1;
        yreq <= 1'b1;
      end
      if (bus_yield_grant && yreq) begin
        yreq <= 1'b0;
        dma_wait <= 1'b0;
        cnt <= stall_len;
      end
    end
  end
endmodule // cpusl_far_model

// ---- sim/testbench.sv ----
// self-checking bench: the bench plays the processor chip, the far model
// plays memory, input port and dma peripheral; inputs move 1 ns after clk rise
`timescale 1ns/1ps
module testbench;
  import cpusl_pkg::*;
  localparam logic [2:0] SEQ [8] = '{STATE_FIRST, STATE_INT_FIRST, STATE_SECOND, STATE_WAIT,
    STATE_THIRD, STATE_STOPPED, STATE_FOURTH, STATE_FIFTH};
  localparam logic [1:0] CYCS [4] = '{CYC_WRITE, CYC_READ, CYC_FETCH, CYC_IO};
  logic       clk = 0, reset = 1, cpu_sync = 0, service_req = 0, stall_go = 0, dma_go = 0, p;
  logic [2:0] state_code_lines = STATE_STOPPED;
  logic [7:0] cpu_data_out = 0, intr_instr_data = 0, stall_len = 0, peri_byte = 0, lo;
  logic [7:0] mem_read_data, peri_in_data, cpu_data_in, state_outputs, addr_low, addr_high;
  logic [7:0] data_out, status_flags, shadow [256], eq [$], gq [$];
  logic       slow_memory_stall_req, bus_yield_req, phase1, phase2, cpu_data_in_oe_n, cpu_ready;
  logic       cpu_interrupt, fetch_cycle, mem_read_cycle, mem_write_cycle, io_cycle, addr_oe_n;
  logic       data_out_oe_n, mem_write_n, mem_rw_oe_n, io_write_strobe, io_read_strobe;
  logic       io_strobe_oe_n, wait_ack, service_req_seen, bus_yield_grant, combined_phase_n;
  logic       sync_buffered, third_state_aux, stop_service_req = 0;
  int         fail_count = 0, checks_done = 0, n, ov, kq [$];
  cpusl_top cpusl_top_inst (.clk, .reset, .state_code_lines, .cpu_sync, .cpu_data_out,
    .mem_read_data, .peri_in_data, .intr_instr_data, .slow_memory_stall_req, .service_req,
    .stop_service_req, .bus_yield_req, .phase1, .phase2, .combined_phase_n,
    .sync_buffered, .third_state_aux, .cpu_data_in, .cpu_data_in_oe_n, .cpu_ready,
    .cpu_interrupt, .fetch_cycle, .mem_read_cycle, .mem_write_cycle, .io_cycle, .state_outputs,
    .addr_low, .addr_high, .addr_oe_n, .data_out, .data_out_oe_n, .mem_write_n, .mem_rw_oe_n,
    .io_write_strobe, .io_read_strobe, .io_strobe_oe_n, .wait_ack, .service_req_seen,
    .bus_yield_grant, .status_flags);
  cpusl_far_model cpusl_far_model_inst (.clk, .reset, .addr_low, .addr_oe_n, .data_out,
    .mem_write_n, .mem_rw_oe_n, .bus_yield_grant, .stall_go, .dma_go, .stall_len, .peri_byte,
    .mem_read_data, .peri_in_data, .slow_memory_stall_req, .bus_yield_req);
  initial forever #50 clk = ~clk;
  initial foreach (shadow[i]) shadow[i] = 8'(i) ^ 8'h5a;
  function automatic logic [7:0] act(int k, logic [7:0] g);
    case (k)
      1: return state_outputs;
      2: return addr_low;
      3: return addr_high;
      4: return {4'h0, fetch_cycle, mem_read_cycle, mem_write_cycle, io_cycle};
      5: return {7'h0, mem_write_n};
      6: return cpu_data_in;
      7: return {7'h0, cpu_data_in_oe_n};
      8: return status_flags;
      9: return {6'h0, wait_ack, cpu_ready};
      10: return {7'h0, bus_yield_grant};
      11: return {4'h0, addr_oe_n, data_out_oe_n, mem_rw_oe_n, io_strobe_oe_n};
      12: return {6'h0, service_req_seen, cpu_interrupt};
      13: return data_out;
      14: return {7'h0, io_write_strobe | io_read_strobe};
      15: return {6'h0, sync_buffered, third_state_aux};
      default: return g;
    endcase
  endfunction
  task automatic note(int k, logic [7:0] e, logic [7:0] g = 8'h00);
    kq.push_back(k);
    eq.push_back(e);
    gq.push_back(g);
  endtask
  task automatic cmp_byte(logic [7:0] e, logic [7:0] a);
    checks_done++;
    if (a !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask
  // oldest note first, read half a clock after the launching edge
  always @(negedge clk) while (kq.size() > 0) cmp_byte(eq.pop_front(),
    act(kq.pop_front(), gq.pop_front()));
  task automatic end_sim;
    if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic lim(int k, int m);
    if (k >= m) begin
      fail_count++;
      end_sim;
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // one processor state: two phase periods, sync high in the first
  task automatic st(logic [2:0] c, logic [7:0] d);
    state_code_lines = c;
    cpu_data_out = d;
    cpu_sync = 1;
    tick(12);
    cpu_sync = 0;
    tick(12);
  endtask
  task automatic sub(logic [1:0] c, logic [7:0] w);
    logic [7:0] hi, f;
    hi = {c, 6'($urandom)};
    f = 8'($urandom);
    st(STATE_FIRST, lo);
    st(STATE_SECOND, hi);
    note(2, lo);
    note(3, hi);
    note(4, c == CYC_FETCH ? 8'h8 : c == CYC_READ ? 8'h4 : c == CYC_WRITE ? 8'h2 : 8'h1);
    note(7, 8'h1);
    note(15, 8'h0);
    state_code_lines = STATE_THIRD;
    cpu_data_out = w;
    cpu_sync = 1;
    tick(8);
    note(15, 8'h3);
    note(5, {7'h0, c != CYC_WRITE});
    note(14, {7'h0, c == CYC_IO});
    if (c != CYC_IO) note(7, {7'h0, c == CYC_WRITE});
    if (c == CYC_READ || c == CYC_FETCH) note(6, shadow[lo]);
    if (c == CYC_WRITE) note(13, w);
    if (c == CYC_WRITE) shadow[lo] = w;
    tick(4);
    cpu_sync = 0;
    tick(12);
    st(STATE_FOURTH, f);
    note(8, f);
  endtask
  initial begin
    void'($urandom(39777));
    peri_byte = 8'($urandom);
    lo = 8'($urandom);
    tick(12);
    reset = 0;
    tick(2);
    n = 0;
    ov = 0;
    for (int i = 0; i < 120; i++) begin
      p = phase1;
      tick(1);
      if (phase1 && !p) n++;
      if (phase1 && phase2) ov++;
      if (combined_phase_n !== !(phase1 || phase2)) ov++;
    end
    note(0, 8'd10, 8'(n));
    note(0, 8'd0, 8'(ov));
    foreach (SEQ[i]) begin
      state_code_lines = SEQ[i];
      tick(3);
      note(1, 8'h1 << i);
    end
    foreach (CYCS[j]) sub(CYCS[j], 8'($urandom));
    for (int v = 0; v < 2; v++) begin
      intr_instr_data = {2'h0, v ? 3'($urandom) : 3'h0, 3'h5};
      service_req = (v == 0);
      stop_service_req = (v == 1);
      for (n = 0; n < 4 && service_req_seen !== 1'b1; n++) st(STATE_STOPPED, 8'h00);
      lim(n, 4);
      service_req = 0;
      stop_service_req = 0;
      tick(2);
      note(12, 8'h3);
      st(STATE_INT_FIRST, lo);
      note(12, 8'h0);
      st(STATE_SECOND, {CYC_FETCH, 6'h00});
      state_code_lines = STATE_THIRD;
      cpu_sync = 1;
      tick(8);
      note(6, intr_instr_data);
      tick(4);
      cpu_sync = 0;
      tick(12);
    end
    state_code_lines = STATE_WAIT;
    for (int v = 0; v < 2; v++) begin
      stall_len = v ? 8'($urandom_range(20, 5)) : 8'd7;
      stall_go = 1;
      tick(1);
      stall_go = 0;
      n = 0;
      for (int i = 0; i < 60; i++) begin
        if (i == 4) note(9, 8'h2);
        n += wait_ack;
        tick(1);
      end
      note(0, 8'h0, 8'(n % 2));
      note(0, 8'h1, 8'(n >= stall_len - 1 && n <= stall_len + 1));
      note(9, 8'h1);
    end
    state_code_lines = STATE_FIRST;
    stall_len = 8'd10;
    dma_go = 1;
    tick(1);
    dma_go = 0;
    tick(20);
    note(10, 8'h0);
    state_code_lines = STATE_WAIT;
    for (n = 0; n < 20 && bus_yield_grant !== 1'b1; n++) tick(1);
    lim(n, 20);
    tick(2);
    note(11, 8'h0f);
    note(1, 8'h00);
    tick(5);
    note(10, 8'h1);
    for (n = 0; n < 30 && bus_yield_grant !== 1'b0; n++) tick(1);
    lim(n, 30);
    tick(2);
    note(11, 8'h00);
    tick(2);
    end_sim;
  end
  initial begin
    #3_000_000;
    fail_count++;
    end_sim;
  end
endmodule // testbench
